// ---- rtl/gpel_global_regs.sv ----
// Global port enable and link indicator registers behind an Avalon-MM slave.
// Assumes the master holds each request until it samples waitrequest low.
`timescale 1ns/100ps

module gpel_global_regs #(
  parameter int PORTS = gpel_pkg::NUM_PORTS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gpel_pkg::gpel_avm_req_t avm_req,
  output gpel_pkg::gpel_avm_rsp_t avm_rsp,
  input wire logic serdes_mode,
  input wire logic [PORTS-1:0] rx_frame_start,
  input wire logic [PORTS-1:0] rx_frame_end,
  output logic [PORTS-1:0] port_active,
  output logic [PORTS-1:0] link_present,
  output logic [PORTS-1:0] rx_stats_commit,
  output logic [PORTS-1:0] serdes_power_down
);
  import gpel_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte address of a register index.
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [ADDR_W-1:0] idx);
    reg_addr = ADDR_W'(idx << WORD_SHIFT);
  endfunction

  // Merge write data into a register through the byte enables; bits above
  // the port count are simply not kept, so they ignore writes.
  function automatic logic [PORTS-1:0] merge_be(input logic [PORTS-1:0] old,
                                                input logic [DATA_W-1:0] wd,
                                                input logic [BE_W-1:0] be);
    logic [PORTS-1:0] res;
    res = old;
    for (int b = 0; b < PORTS; b++) begin
      if (be[b / LANE_W]) begin
        res[b] = wd[b];
      end
    end
    merge_be = res;
  endfunction

  // Zero-extend a port vector onto the bus word.
  function automatic logic [DATA_W-1:0] widen(input logic [PORTS-1:0] v);
    logic [DATA_W-1:0] w;
    w = READ_ZERO;
    w[PORTS-1:0] = v;
    widen = w;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  gpel_bus_state_t state;            // Slave handshake state.
  gpel_bus_state_t next_state;
  logic [PORTS-1:0] port_enable;     // Port enable register.
  logic [PORTS-1:0] next_port_enable;
  logic [PORTS-1:0] link_indicator;  // Link indicator register.
  logic [PORTS-1:0] next_link_indicator;
  logic waitrequest;                 // Registered waitrequest.
  logic next_waitrequest;
  logic [DATA_W-1:0] readdata;       // Registered read data.
  logic [DATA_W-1:0] next_readdata;
  logic hit_enable;                  // Address selects the port enable register.
  logic hit_link;                    // Address selects the link indicator register.

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Only whole-word aligned addresses hit; anything else is unmapped.
  always_comb begin
    hit_enable = 1'b0;
    hit_link = 1'b0;
    if (avm_req.address == reg_addr(IDX_PORT_ENABLE)) begin
      hit_enable = 1'b1;
    end else if (avm_req.address == reg_addr(IDX_LINK_INDICATOR)) begin
      hit_link = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Bus handshake and register update
  // ----------------------------------------------------------------------
  // Every access takes two cycles: the request is seen in IDLE, and the
  // answer stands for exactly one cycle in ANSWER. Writes land on the edge
  // where the master sees waitrequest low, so a held request never writes
  // twice. The fixed latency costs a cycle but keeps the slave trivial.
  always_comb begin
    next_state = state;
    next_waitrequest = waitrequest;
    next_readdata = readdata;
    next_port_enable = port_enable;
    next_link_indicator = link_indicator;
    case (state)
      GPEL_IDLE: begin
        // A request is taken; prepare the answer for the next cycle.
        if (avm_req.read | avm_req.write) begin
          next_state = GPEL_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = READ_ZERO;
          if (avm_req.read & hit_enable) begin
            next_readdata = widen(port_enable);
          end else if (avm_req.read & hit_link) begin
            next_readdata = widen(link_indicator);
          end
        end
      end
      GPEL_ANSWER: begin
        // The master samples waitrequest low here; commit any write.
        next_state = GPEL_IDLE;
        next_waitrequest = 1'b1;
        next_readdata = READ_ZERO;
        if (avm_req.write & hit_enable) begin
          next_port_enable = merge_be(port_enable, avm_req.writedata,
                                      avm_req.byteenable);
        end else if (avm_req.write & hit_link) begin
          next_link_indicator = merge_be(link_indicator, avm_req.writedata,
                                         avm_req.byteenable);
        end
      end
      default: begin
        next_state = GPEL_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= GPEL_IDLE;
      waitrequest <= 1'b1;
      readdata <= READ_ZERO;
      port_enable <= RST_PORT_ENABLE;
      link_indicator <= RST_LINK_INDICATOR;
    end else begin
      state <= next_state;
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      port_enable <= next_port_enable;
      link_indicator <= next_link_indicator;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Register values drive the ports directly; no extra stage is added.
  always_comb begin
    avm_rsp.waitrequest = waitrequest;
    avm_rsp.readdata = readdata;
    port_active = port_enable;
    link_present = link_indicator;
  end

  // ----------------------------------------------------------------------
  // Receive statistics gate
  // ----------------------------------------------------------------------
  gpel_rx_stats_gate #(
    .PORTS(PORTS)
  ) u_stats_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .serdes_mode(serdes_mode),
    .port_enable(port_enable),
    .rx_frame_start(rx_frame_start),
    .rx_frame_end(rx_frame_end),
    .rx_stats_commit(rx_stats_commit),
    .serdes_power_down(serdes_power_down)
  );

endmodule // gpel_global_regs

// ---- include/gpel_pkg.sv ----
// Package for the global port enable and link indicator register pair.
// Assumes a 40 MHz core clock and an Avalon-MM slave port with waitrequest.
package gpel_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS = 10;   // Ten MAC ports, one bit each.
  localparam int ADDR_W = 13;      // Byte address width; wide enough for word 0x502 times four.
  localparam int DATA_W = 32;      // Avalon data width.
  localparam int BE_W = 4;         // Byte enables for a 32-bit word.
  localparam int LANE_W = 8;       // Bits per byte lane.
  localparam int WORD_SHIFT = 2;   // Register index to byte address.

  // ----------------------------------------------------------------------
  // Register map (printed offsets are indices; byte address is four times)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_PORT_ENABLE = 13'h0500;
  localparam logic [ADDR_W-1:0] IDX_LINK_INDICATOR = 13'h0502;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0] RST_PORT_ENABLE = 10'h3ff;  // All ports active.
  localparam logic [NUM_PORTS-1:0] RST_LINK_INDICATOR = 10'h000;  // No link.
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;  // Unmapped and reserved read.

  // ----------------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic read;                  // Read request.
    logic write;                 // Write request.
    logic [ADDR_W-1:0] address;  // Byte address.
    logic [DATA_W-1:0] writedata;  // Write data.
    logic [BE_W-1:0] byteenable;   // Byte lanes written.
  } gpel_avm_req_t;

  typedef struct packed {
    logic waitrequest;            // High while the answer is not ready.
    logic [DATA_W-1:0] readdata;  // Read data, valid when waitrequest is low.
  } gpel_avm_rsp_t;

  // Slave handshake states.
  typedef enum logic {GPEL_IDLE, GPEL_ANSWER} gpel_bus_state_t;

endpackage

// ---- rtl/gpel_rx_stats_gate.sv ----
// Per-port gate for receive statistics updates.
// Assumes frame start and end pulses are synchronous to mclk, one per port.
`timescale 1ns/100ps

module gpel_rx_stats_gate #(
  parameter int PORTS = gpel_pkg::NUM_PORTS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic serdes_mode,
  input wire logic [PORTS-1:0] port_enable,
  input wire logic [PORTS-1:0] rx_frame_start,
  input wire logic [PORTS-1:0] rx_frame_end,
  output logic [PORTS-1:0] rx_stats_commit,
  output logic [PORTS-1:0] serdes_power_down
);
  import gpel_pkg::*;

  logic [PORTS-1:0] in_frame;       // A receive frame is in progress.
  logic [PORTS-1:0] spoiled;        // The frame lost its port mid-way in serializer mode.
  logic [PORTS-1:0] next_in_frame;
  logic [PORTS-1:0] next_spoiled;
  logic [PORTS-1:0] next_commit;
  logic [PORTS-1:0] next_power_down;

  // ----------------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------------
  // In serializer mode, a frame cut by a disable never reaches the counters,
  // since the serializer has powered down under it and its tail is garbage.
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      next_in_frame[p] = (in_frame[p] | rx_frame_start[p]) & ~rx_frame_end[p];
      next_spoiled[p] = spoiled[p];
      if (rx_frame_start[p]) begin
        next_spoiled[p] = 1'b0;
      end
      if ((in_frame[p] | rx_frame_start[p]) & ~port_enable[p] & serdes_mode) begin
        next_spoiled[p] = 1'b1;
      end
      if (rx_frame_end[p]) begin
        next_spoiled[p] = 1'b0;
      end
      next_commit[p] = rx_frame_end[p] & port_enable[p] & ~spoiled[p];
      next_power_down[p] = serdes_mode & ~port_enable[p];
    end
  end

  // Registers only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_frame <= '0;
      spoiled <= '0;
      rx_stats_commit <= '0;
      serdes_power_down <= '0;
    end else begin
      in_frame <= next_in_frame;
      spoiled <= next_spoiled;
      rx_stats_commit <= next_commit;
      serdes_power_down <= next_power_down;
    end
  end

endmodule // gpel_rx_stats_gate

// ---- verification/gpel_regs_sva.sv ----
// Checker for the global port enable and link indicator registers.
// Sees only the top module's ports; byte address is the register index times four.
`timescale 1ns/100ps

module gpel_regs_sva #(
  parameter int PORTS = gpel_pkg::NUM_PORTS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gpel_pkg::gpel_avm_req_t avm_req,
  input wire gpel_pkg::gpel_avm_rsp_t avm_rsp,
  input wire logic serdes_mode,
  input wire logic [PORTS-1:0] rx_frame_start,
  input wire logic [PORTS-1:0] rx_frame_end,
  input wire logic [PORTS-1:0] port_active,
  input wire logic [PORTS-1:0] link_present,
  input wire logic [PORTS-1:0] rx_stats_commit,
  input wire logic [PORTS-1:0] serdes_power_down
);
  import gpel_pkg::*;
  // --------------------------------------------------------------------
  // Decoded bus events
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_PE = IDX_PORT_ENABLE << WORD_SHIFT; // Enable word.
  localparam logic [ADDR_W-1:0] A_LI = IDX_LINK_INDICATOR << WORD_SHIFT; // Link word.
  wire logic done = !avm_rsp.waitrequest; // The edge where the master sees the answer.
  wire logic wr_pe = done && avm_req.write && avm_req.address == A_PE; // Enable write.
  wire logic wr_li = done && avm_req.write && avm_req.address == A_LI; // Link write.
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A request seen while the slave is idle, then a one-cycle answer.
  sequence s_take;
    (avm_req.read || avm_req.write) && avm_rsp.waitrequest;
  endsequence
  sequence s_answer;
    !avm_rsp.waitrequest ##1 avm_rsp.waitrequest;
  endsequence
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  a_answer_time: assert property (s_take |-> ##1 s_answer)
    else $error("bus answer not one cycle after request");
  a_pe_low: assert property (wr_pe && avm_req.byteenable[0] |=>
    port_active[7:0] == $past(avm_req.writedata[7:0])) else $error("enable low byte wrong");
  a_pe_high: assert property (wr_pe && avm_req.byteenable[1] |=>
    port_active[9:8] == $past(avm_req.writedata[9:8])) else $error("enable high bits wrong");
  a_pe_hold: assert property (!wr_pe |=> $stable(port_active))
    else $error("port enables changed without a write");
  a_li_write: assert property (wr_li && avm_req.byteenable == 4'hf |=>
    link_present == $past(avm_req.writedata[PORTS-1:0])) else $error("link bits wrong");
  a_read_upper: assert property (done && avm_req.read |-> avm_rsp.readdata[31:10] == '0)
    else $error("upper read bits not zero");
  a_read_pe: assert property (done && avm_req.read && avm_req.address == A_PE |->
    avm_rsp.readdata == DATA_W'(port_active)) else $error("enable readback wrong");
  a_power_down: assert property (1'b1 |=> serdes_power_down ==
    ($past(serdes_mode) ? ~$past(port_active) : '0)) else $error("power down wrong");
  a_commit_cause: assert property (1'b1 |=>
    (rx_stats_commit & ~$past(rx_frame_end)) == '0) else $error("commit without frame end");
endmodule // gpel_regs_sva

bind gpel_global_regs gpel_regs_sva #(.PORTS(PORTS)) u_gpel_regs_sva (.mclk, .rst_n,
  .avm_req, .avm_rsp, .serdes_mode, .rx_frame_start, .rx_frame_end, .port_active,
  .link_present, .rx_stats_commit, .serdes_power_down);

// ---- verification/tb.sv ----
// Self-checking bench for the global register pair.
// Drives the Avalon-MM slave and the frame pulses itself; the checker is bound in.
`timescale 1ns/100ps

module tb;
  import gpel_pkg::*;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_PE = IDX_PORT_ENABLE << WORD_SHIFT; // Enable word.
  localparam logic [ADDR_W-1:0] A_LI = IDX_LINK_INDICATOR << WORD_SHIFT; // Link word.
  localparam logic [ADDR_W-1:0] A_GAP = A_PE + 13'h0004; // Unmapped word between them.
  logic mclk = 1'b0; // Core clock.
  logic rst_n = 1'b0; // Reset, active low.
  gpel_avm_req_t req = '0; // Bus request.
  gpel_avm_rsp_t rsp; // Bus answer.
  logic serdes_mode = 1'b0; // Serializer mode.
  logic [NUM_PORTS-1:0] fs = '0, fe = '0, act, lnk, com, pdn;
  logic [31:0] rd; // Last read data.
  int n_mismatch = 0;
  int checks_done = 0;

  always #12.5 mclk = ~mclk; // 40 MHz.

  gpel_global_regs u_gpel_global_regs (.mclk(mclk), .rst_n(rst_n), .avm_req(req),
    .avm_rsp(rsp), .serdes_mode(serdes_mode), .rx_frame_start(fs), .rx_frame_end(fe),
    .port_active(act), .link_present(lnk), .rx_stats_commit(com), .serdes_power_down(pdn));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is seen low.
  task automatic bus(input bit wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge mclk);
    req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (!rsp.waitrequest) break;
    end
    if (k == 20) begin
      n_mismatch++; // A hung slave ends the run.
      end_of_test();
    end
    rd = rsp.readdata; // Taken at the answer edge only.
    req <= '0;
    // A write lands on the answer edge, so let one more edge pass before
    // the caller looks at the register outputs.
    @(posedge mclk);
  endtask

  // A frame on port p; cut drops the port mid-frame, exp is the commit expected.
  task automatic frame(input int p, input bit cut, input logic exp);
    @(posedge mclk) fs[p] <= 1'b1;
    @(posedge mclk) fs[p] <= 1'b0;
    if (cut) begin
      bus(1, A_PE, 32'h0000_03ff & ~(32'h1 << p), 4'hf);
      #1 chk(pdn[p], serdes_mode);
      bus(1, A_PE, 32'h0000_03ff, 4'hf);
    end
    @(posedge mclk) fe[p] <= 1'b1;
    @(posedge mclk) fe[p] <= 1'b0;
    #1 chk(com[p], exp);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, A_PE, '0, 4'hf);
    chk(rd, 32'h0000_03ff);
    bus(0, A_LI, '0, 4'hf);
    chk(rd, 32'h0);
    for (int i = 0; i < NUM_PORTS; i++) begin
      bus(1, A_PE, 32'h1 << i, 4'hf);
      chk(act, 32'h1 << i);
    end
    bus(0, A_PE, '0, 4'hf);
    chk(rd, 32'h0000_0200);
    bus(1, A_PE, 32'hffff_fdff, 4'hf);
    bus(0, A_PE, '0, 4'hf);
    chk(rd, 32'h0000_01ff);
    bus(1, A_PE, 32'h0000_0000, 4'h1);
    chk(act, 32'h0000_0100);
    bus(1, A_LI, 32'hffff_fea5, 4'hf);
    bus(0, A_LI, '0, 4'hf);
    chk(rd, 32'h0000_02a5);
    chk(lnk, 32'h0000_02a5);
    bus(1, A_GAP, 32'hffff_ffff, 4'hf);
    bus(0, A_GAP, '0, 4'hf);
    chk(rd, 32'h0);
    chk(act, 32'h0000_0100);
    bus(1, A_PE, 32'h0000_03ff, 4'hf);
    serdes_mode <= 1'b1;
    frame(3, 1'b1, 1'b0);
    frame(3, 1'b0, 1'b1);
    @(posedge mclk) serdes_mode <= 1'b0;
    frame(9, 1'b1, 1'b1);
    bus(1, A_PE, 32'h0, 4'hf);
    @(posedge mclk) rst_n <= 1'b0;
    @(posedge mclk) rst_n <= 1'b1;
    #1 chk(act, 32'h0000_03ff);
    chk(lnk, 32'h0);
    end_of_test();
  end
endmodule // tb
